/* include/tmar_consts.svh */
// Offsets, field positions, reset values and codes of the alert/status register block
// What this block does
// - Write to FCh resets all but the handshake, releases pins
// - Acknowledge general call address 00000000
// - General call byte 06h resets; others ignored
// - Pins assert after programmed consecutive violations
// - Status flags set on first violation
// - Count codes 000/001/011/111 mean 1..4
// - Bits 6:4 overtemp, 3:1 fault; POR 70h
// - Hysteresis at 21h, unsigned, POR 0Ah
// - Host keeps hysteresis below all limits
// - Pointer FEh reads fixed maker byte
// - Pointer FDh reads variant device byte
// - Identification registers ignore writes
// - Open flags: bit 2 remote2, bit 1 remote1
// - Read clears high/low/open flags only if cause ended; overtemp flags follow the cause
// - Channel mask gates fault pin contribution
// - High flags per channel, plus summary bit
// - Low flags per channel, plus summary bit
// - Overtemp flags per channel, plus summary bit
`ifndef TMAR_CONSTS_SVH
`define TMAR_CONSTS_SVH

// ----------------------------------------------------------------
// Pointer map
// ----------------------------------------------------------------
`define TMAR_PTR_STATUS   8'h02
`define TMAR_PTR_MASK     8'h1f
`define TMAR_PTR_OPEN     8'h1b
`define TMAR_PTR_HYST     8'h21
`define TMAR_PTR_CONSEC   8'h22
`define TMAR_PTR_HIGHF    8'h35
`define TMAR_PTR_LOWF     8'h36
`define TMAR_PTR_OTF      8'h37
`define TMAR_PTR_SWRST    8'hfc
`define TMAR_PTR_DEVID    8'hfd
`define TMAR_PTR_MAKER    8'hfe

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define TMAR_POR_HYST     8'h0a
`define TMAR_POR_CONSEC   8'h70
`define TMAR_POR_MASK     8'h00
`define TMAR_GC_RESET     8'h06
`define TMAR_CONSEC_WMASK 8'h7e

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMAR_OT_CNT_MSB   6
`define TMAR_OT_CNT_LSB   4
`define TMAR_FLT_CNT_MSB  3
`define TMAR_FLT_CNT_LSB  1
`define TMAR_ST_HIGH      4
`define TMAR_ST_LOW       3
`define TMAR_ST_OPEN      2
`define TMAR_ST_OT        1
`define TMAR_ST_FLTPIN    7
`define TMAR_ST_OTPIN     0
`define TMAR_NCH          3

`endif

/* include/tmar_pkg.sv */
// Types and decode helpers of the alert/status register block
package tmar_pkg;

  typedef enum logic [1:0] {
    TMAR_REQ_WR = 2'b00,
    TMAR_REQ_RD = 2'b01,
    TMAR_REQ_GC = 2'b10
  } tmar_req_t;

  typedef logic [2:0] tmar_cnt_t;

  // Unlisted codes count their set bits, so the decode stays monotonic
  function automatic tmar_cnt_t need_count(input logic [2:0] code);
    tmar_cnt_t n;
    n = 3'h1;
    unique case (code)
      3'b000:  n = 3'h1;
      3'b001:  n = 3'h2;
      3'b011:  n = 3'h3;
      3'b111:  n = 3'h4;
      default: n = 3'h1 + tmar_cnt_t'(code[0]) + tmar_cnt_t'(code[1]) + tmar_cnt_t'(code[2]);
    endcase
    return n;
  endfunction : need_count

endpackage : tmar_pkg

/* include/tmar_xfer_if.sv */
// Request/answer crossing between the link-clock side and the core
interface tmar_xfer_if;
  logic                req_tgl;
  tmar_pkg::tmar_req_t kind;
  logic [7:0]          ptr;
  logic [7:0]          wdata;
  logic                ack_tgl;
  logic [7:0]          rdata;

  modport link (output req_tgl, output kind, output ptr, output wdata, input ack_tgl, input rdata);
  modport core (input req_tgl, input kind, input ptr, input wdata, output ack_tgl, output rdata);
endinterface : tmar_xfer_if

/* rtl/tmar_link.sv */
// Link-clock side: takes protocol-engine strobes and hands them to the core
`include "tmar_consts.svh"
module tmar_link (
  // Link clock and core reset
  input  wire logic       link_clk_i,
  input  wire logic       reset_i,
  // Protocol engine, link clock domain
  input  wire logic       wr_stb_i,
  input  wire logic       rd_stb_i,
  input  wire logic       gc_addr_i,
  input  wire logic       gc_byte_stb_i,
  input  wire logic [7:0] ptr_i,
  input  wire logic [7:0] wdata_i,
  output logic            gc_ack_o,
  output logic            busy_o,
  output logic            rd_valid_o,
  output logic [7:0]      rdata_o,
  // Core side
  tmar_xfer_if.link       xf
);
  logic [1:0]          rst_sync_reg;
  logic                rst_l;
  logic                ack_s1_reg;
  logic                ack_s2_reg;
  logic                ack_s3_reg;
  logic                req_tgl_reg;
  tmar_pkg::tmar_req_t kind_reg;
  logic [7:0]          ptr_reg;
  logic [7:0]          wdata_reg;
  logic                gc_armed_reg;
  logic                rd_wait_reg;
  logic                rd_valid_reg;
  logic [7:0]          rdata_reg;
  logic                take;

  // ----------------------------------------------------------------
  // Reset and answer synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i) begin
    rst_sync_reg <= {rst_sync_reg[0], reset_i};
  end
  assign rst_l = rst_sync_reg[1];

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= xf.ack_tgl;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Request launch; payload is frozen while busy
  // ----------------------------------------------------------------
  assign busy_o   = req_tgl_reg ^ ack_s2_reg;
  assign gc_ack_o = gc_addr_i;
  assign take     = !busy_o && (wr_stb_i || rd_stb_i || (gc_byte_stb_i && gc_armed_reg));

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      gc_armed_reg <= 1'b0;
    end else if (gc_addr_i) begin
      gc_armed_reg <= 1'b1;
    end else if (gc_byte_stb_i) begin
      gc_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      req_tgl_reg <= 1'b0;
      kind_reg    <= tmar_pkg::TMAR_REQ_WR;
      ptr_reg     <= 8'h00;
      wdata_reg   <= 8'h00;
    end else if (take) begin
      req_tgl_reg <= ~req_tgl_reg;
      ptr_reg     <= ptr_i;
      wdata_reg   <= wdata_i;
      if (gc_byte_stb_i && gc_armed_reg) begin
        kind_reg <= tmar_pkg::TMAR_REQ_GC;
      end else if (rd_stb_i) begin
        kind_reg <= tmar_pkg::TMAR_REQ_RD;
      end else begin
        kind_reg <= tmar_pkg::TMAR_REQ_WR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      rd_wait_reg  <= 1'b0;
      rd_valid_reg <= 1'b0;
      rdata_reg    <= 8'h00;
    end else begin
      rd_valid_reg <= 1'b0;
      if (rd_wait_reg && (ack_s2_reg ^ ack_s3_reg)) begin
        rd_wait_reg  <= 1'b0;
        rd_valid_reg <= 1'b1;
        rdata_reg    <= xf.rdata;
      end
      // Next read may be taken on the edge the previous one completes
      if (take && rd_stb_i && !(gc_byte_stb_i && gc_armed_reg)) begin
        rd_wait_reg <= 1'b1;
      end
    end
  end

  assign rd_valid_o = rd_valid_reg;
  assign rdata_o    = rdata_reg;
  assign xf.req_tgl = req_tgl_reg;
  assign xf.kind    = kind_reg;
  assign xf.ptr     = ptr_reg;
  assign xf.wdata   = wdata_reg;

  link_busy_a: assert property (@(posedge link_clk_i) disable iff (rst_l)
    take |=> busy_o) else $error("request taken but link not busy");
endmodule : tmar_link

/* rtl/tmar_regs.sv */
// Alert/status register core of the temperature monitor, with its link-side front end
`include "tmar_consts.svh"
module tmar_regs #(
  parameter logic [7:0] MAKER_ID   = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_ID_ONE = 8'ha1, // Arbitrary value
  parameter logic [7:0] DEV_ID_TWO = 8'ha2, // Arbitrary value
  parameter bit         TWO_REMOTE = 1'b1
) (
  // Core clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  // Link clock and protocol engine
  input  wire logic       link_clk_i,
  input  wire logic       wr_stb_i,
  input  wire logic       rd_stb_i,
  input  wire logic       gc_addr_i,
  input  wire logic       gc_byte_stb_i,
  input  wire logic [7:0] ptr_i,
  input  wire logic [7:0] wdata_i,
  output logic            gc_ack_o,
  output logic            busy_o,
  output logic            rd_valid_o,
  output logic [7:0]      rdata_o,
  // Conversion results, core clock domain
  input  wire logic       conv_done_i,
  input  wire logic [1:0] conv_chan_i,
  input  wire logic       high_exceed_i,
  input  wire logic       low_exceed_i,
  input  wire logic       ot_exceed_i,
  input  wire logic       open_diode_i,
  output logic            abort_conv_o,
  output logic [7:0]      hysteresis_o,
  // Open-drain pins
  input  wire logic       fault_pin_i,
  output logic            fault_pin_o,
  output logic            fault_pin_oe_o,
  input  wire logic       ot_pin_i,
  output logic            ot_pin_o,
  output logic            ot_pin_oe_o
);
  localparam int NCH = `TMAR_NCH;

  tmar_xfer_if xf ();

  logic                req_s1_reg;
  logic                req_s2_reg;
  logic                req_s3_reg;
  logic                ack_tgl_reg;
  logic [7:0]          rdata_reg;
  logic                new_req;
  logic                soft_rst;
  logic                rst_all;
  logic [7:0]          hyst_reg;
  logic [7:0]          consec_reg;
  logic [7:0]          mask_reg;
  logic [NCH-1:0]      cond_high_reg;
  logic [NCH-1:0]      cond_low_reg;
  logic [NCH-1:0]      cond_ot_reg;
  logic [NCH-1:0]      cond_open_reg;
  logic [NCH-1:0]      high_flags_reg;
  logic [NCH-1:0]      low_flags_reg;
  logic [NCH-1:0]      ot_flags_reg;
  logic [NCH-1:0]      open_flags_reg;
  tmar_pkg::tmar_cnt_t flt_cnt_reg [NCH];
  tmar_pkg::tmar_cnt_t ot_cnt_reg  [NCH];
  tmar_pkg::tmar_cnt_t flt_need;
  tmar_pkg::tmar_cnt_t ot_need;
  logic                flt_any;
  logic                ot_any;
  logic                fault_oe_reg;
  logic                ot_oe_reg;
  logic                abort_reg;
  logic [1:0]          fpin_sync_reg;
  logic [1:0]          opin_sync_reg;
  logic [NCH-1:0]      conv_hit;
  logic [NCH-1:0]      open_valid;
  logic                rd_high;
  logic                rd_low;
  logic                rd_open;
  logic [7:0]          status;
  logic [7:0]          rd_mux;

  tmar_link u_link (
    .link_clk_i    (link_clk_i),
    .reset_i       (reset_i),
    .wr_stb_i      (wr_stb_i),
    .rd_stb_i      (rd_stb_i),
    .gc_addr_i     (gc_addr_i),
    .gc_byte_stb_i (gc_byte_stb_i),
    .ptr_i         (ptr_i),
    .wdata_i       (wdata_i),
    .gc_ack_o      (gc_ack_o),
    .busy_o        (busy_o),
    .rd_valid_o    (rd_valid_o),
    .rdata_o       (rdata_o),
    .xf            (xf.link)
  );

  // ----------------------------------------------------------------
  // Request crossing and decode
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= xf.req_tgl;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  assign new_req  = req_s2_reg ^ req_s3_reg;
  assign soft_rst = new_req && (
      (xf.kind == tmar_pkg::TMAR_REQ_WR && xf.ptr == `TMAR_PTR_SWRST) ||
      (xf.kind == tmar_pkg::TMAR_REQ_GC && xf.wdata == `TMAR_GC_RESET));
  // Handshake state survives a soft reset so the link never hangs
  assign rst_all  = reset_i || soft_rst;

  function automatic logic wr_hit(input logic [7:0] p);
    return new_req && xf.kind == tmar_pkg::TMAR_REQ_WR && xf.ptr == p;
  endfunction : wr_hit

  function automatic logic rd_hit(input logic [7:0] p);
    return new_req && xf.kind == tmar_pkg::TMAR_REQ_RD && xf.ptr == p;
  endfunction : rd_hit

  assign rd_high = rd_hit(`TMAR_PTR_HIGHF);
  assign rd_low  = rd_hit(`TMAR_PTR_LOWF);
  assign rd_open = rd_hit(`TMAR_PTR_OPEN);

  // ----------------------------------------------------------------
  // Writable registers; identification pointers have no write path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      hyst_reg <= `TMAR_POR_HYST;
    end else if (wr_hit(`TMAR_PTR_HYST)) begin
      hyst_reg <= xf.wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      consec_reg <= `TMAR_POR_CONSEC;
    end else if (wr_hit(`TMAR_PTR_CONSEC)) begin
      consec_reg <= xf.wdata & `TMAR_CONSEC_WMASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      mask_reg <= `TMAR_POR_MASK;
    end else if (wr_hit(`TMAR_PTR_MASK)) begin
      mask_reg <= {5'h00, xf.wdata[2:0]};
    end
  end

  // Comparator uses this; values at or above a limit stop it releasing
  assign hysteresis_o = hyst_reg;

  // ----------------------------------------------------------------
  // Latest per-channel conditions, sticky high/low/open flags and live overtemp flags
  // ----------------------------------------------------------------
  always_comb begin
    conv_hit = '0;
    if (conv_done_i && conv_chan_i < 2'(NCH)) begin
      conv_hit[conv_chan_i] = 1'b1;
    end
  end
  // Local channel has no diode; remote 2 only in the two-remote variant
  assign open_valid = {TWO_REMOTE, 1'b1, 1'b0};

  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      cond_high_reg <= '0;
      cond_low_reg  <= '0;
      cond_ot_reg   <= '0;
      cond_open_reg <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (conv_hit[c]) begin
          cond_high_reg[c] <= high_exceed_i;
          cond_low_reg[c]  <= low_exceed_i;
          cond_ot_reg[c]   <= ot_exceed_i;
          cond_open_reg[c] <= open_diode_i && open_valid[c];
        end
      end
    end
  end

  // Set wins over the read clear; clear needs the cause gone
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      high_flags_reg <= '0;
      low_flags_reg  <= '0;
      ot_flags_reg   <= '0;
      open_flags_reg <= '0;
    end else begin
      high_flags_reg <= (high_flags_reg & ~({NCH{rd_high}} & ~cond_high_reg))
                        | (conv_hit & {NCH{high_exceed_i}});
      low_flags_reg  <= (low_flags_reg & ~({NCH{rd_low}} & ~cond_low_reg))
                        | (conv_hit & {NCH{low_exceed_i}});
      ot_flags_reg   <= (cond_ot_reg & ~conv_hit)
                        | (conv_hit & {NCH{ot_exceed_i}});
      open_flags_reg <= (open_flags_reg & ~({NCH{rd_open}} & ~cond_open_reg))
                        | (conv_hit & open_valid & {NCH{open_diode_i}});
    end
  end

  // ----------------------------------------------------------------
  // Consecutive-violation filters for the two pins
  // ----------------------------------------------------------------
  assign flt_need = tmar_pkg::need_count(consec_reg[`TMAR_FLT_CNT_MSB:`TMAR_FLT_CNT_LSB]);
  assign ot_need  = tmar_pkg::need_count(consec_reg[`TMAR_OT_CNT_MSB:`TMAR_OT_CNT_LSB]);

  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      for (int c = 0; c < NCH; c++) begin
        flt_cnt_reg[c] <= 3'h0;
        ot_cnt_reg[c]  <= 3'h0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (conv_hit[c]) begin
          // Mask set keeps the channel off the fault pin only
          if ((high_exceed_i || low_exceed_i || (open_diode_i && open_valid[c])) && !mask_reg[c]) begin
            flt_cnt_reg[c] <= (flt_cnt_reg[c] == 3'h4) ? 3'h4 : flt_cnt_reg[c] + 3'h1;
          end else begin
            flt_cnt_reg[c] <= 3'h0;
          end
          if (ot_exceed_i) begin
            ot_cnt_reg[c] <= (ot_cnt_reg[c] == 3'h4) ? 3'h4 : ot_cnt_reg[c] + 3'h1;
          end else begin
            ot_cnt_reg[c] <= 3'h0;
          end
        end
      end
    end
  end

  always_comb begin
    flt_any = 1'b0;
    ot_any  = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (flt_cnt_reg[c] >= flt_need) flt_any = 1'b1;
      if (ot_cnt_reg[c] >= ot_need)   ot_any  = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      fault_oe_reg <= 1'b0;
      ot_oe_reg    <= 1'b0;
    end else begin
      fault_oe_reg <= flt_any;
      ot_oe_reg    <= ot_any;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= soft_rst;
    end
  end

  assign fault_pin_o    = 1'b0;
  assign fault_pin_oe_o = fault_oe_reg;
  assign ot_pin_o       = 1'b0;
  assign ot_pin_oe_o    = ot_oe_reg;
  assign abort_conv_o   = abort_reg;

  // ----------------------------------------------------------------
  // Pin readback and read path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fpin_sync_reg <= 2'b11;
      opin_sync_reg <= 2'b11;
    end else begin
      fpin_sync_reg <= {fpin_sync_reg[0], fault_pin_i};
      opin_sync_reg <= {opin_sync_reg[0], ot_pin_i};
    end
  end

  always_comb begin
    status                = 8'h00;
    status[`TMAR_ST_HIGH] = |high_flags_reg;
    status[`TMAR_ST_LOW]  = |low_flags_reg;
    status[`TMAR_ST_OT]   = |ot_flags_reg;
    status[`TMAR_ST_OPEN] = |open_flags_reg;
    status[`TMAR_ST_FLTPIN] = !fpin_sync_reg[1];
    status[`TMAR_ST_OTPIN]  = !opin_sync_reg[1];
  end

  always_comb begin
    unique case (xf.ptr)
      `TMAR_PTR_STATUS: rd_mux = status;
      `TMAR_PTR_MASK:   rd_mux = mask_reg;
      `TMAR_PTR_OPEN:   rd_mux = {5'h00, open_flags_reg};
      `TMAR_PTR_HYST:   rd_mux = hyst_reg;
      `TMAR_PTR_CONSEC: rd_mux = consec_reg;
      `TMAR_PTR_HIGHF:  rd_mux = {5'h00, high_flags_reg};
      `TMAR_PTR_LOWF:   rd_mux = {5'h00, low_flags_reg};
      `TMAR_PTR_OTF:    rd_mux = {5'h00, ot_flags_reg};
      `TMAR_PTR_DEVID:  rd_mux = TWO_REMOTE ? DEV_ID_TWO : DEV_ID_ONE;
      `TMAR_PTR_MAKER:  rd_mux = MAKER_ID;
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_tgl_reg <= 1'b0;
      rdata_reg   <= 8'h00;
    end else if (new_req) begin
      ack_tgl_reg <= ~ack_tgl_reg;
      if (xf.kind == tmar_pkg::TMAR_REQ_RD) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign xf.ack_tgl = ack_tgl_reg;
  assign xf.rdata   = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  swrst_write_a: assert property (wr_hit(`TMAR_PTR_SWRST) |=> hyst_reg == 8'h0a && consec_reg == 8'h70
    && !fault_pin_oe_o && !ot_pin_oe_o ##1 !abort_conv_o) else $error("pointer reset did not restore state");
  gc_reset_a: assert property (new_req && xf.kind == tmar_pkg::TMAR_REQ_GC && xf.wdata == 8'h06
    |=> abort_conv_o && consec_reg == 8'h70) else $error("general call reset ignored");
  gc_other_a: assert property (new_req && xf.kind == tmar_pkg::TMAR_REQ_GC && xf.wdata != 8'h06
    |=> !abort_conv_o && $stable(hyst_reg)) else $error("general call byte acted");
  consec_zero_a: assert property (consec_reg[7] == 1'b0 && consec_reg[0] == 1'b0)
    else $error("reserved count bits set");
  first_flag_a: assert property (!soft_rst && conv_done_i && conv_chan_i == 2'd1 && high_exceed_i
    |=> high_flags_reg[1] && status[4]) else $error("high flag missed on first violation");
  pin_filter_a: assert property (!$past(rst_all) |-> fault_pin_oe_o == $past(flt_any))
    else $error("fault pin does not follow filter");
  maker_read_a: assert property (rd_hit(`TMAR_PTR_MAKER) |=> rdata_reg == MAKER_ID)
    else $error("maker byte wrong");
  id_write_a: assert property (wr_hit(`TMAR_PTR_DEVID) |=> !abort_conv_o && $stable(hyst_reg)
    && $stable(consec_reg) && $stable(mask_reg))
    else $error("identification write acted");
  rc_keep_a: assert property (rd_high |=> (high_flags_reg & $past(cond_high_reg & high_flags_reg))
    == $past(cond_high_reg & high_flags_reg) || $past(soft_rst)) else $error("flag cleared while cause held");
  req_ack_a: assert property (new_req |=> ack_tgl_reg != $past(ack_tgl_reg))
    else $error("request not answered");

  swrst_c: cover property (wr_hit(`TMAR_PTR_SWRST));
  gcrst_c: cover property (soft_rst && xf.kind == tmar_pkg::TMAR_REQ_GC);
  pin_rise_c: cover property ($rose(fault_pin_oe_o) ##1 flt_need == 3'h4);
  rd_clear_c: cover property (rd_high && high_flags_reg != '0 && cond_high_reg == '0);
endmodule : tmar_regs

/* dv/tmar_host_model.sv */
// Host controller model issuing register requests on the link side
module tmar_host_model (
  // Link side
  input  wire logic       link_clk_i,
  input  wire logic       busy_i,
  output logic            wr_stb_o,
  output logic            rd_stb_o,
  output logic            gc_addr_o,
  output logic            gc_byte_stb_o,
  output logic [7:0]      ptr_o,
  output logic [7:0]      wdata_o,
  // Run health
  output int              n_stall_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wr_stb_o, rd_stb_o, gc_addr_o, gc_byte_stb_o, ptr_o, wdata_o} = 20'h0;
  initial n_stall_o = 0;
  // Kind 0 write, 1 read, 2 general call; one request in flight at a time
  task automatic req(input int k, input logic [7:0] p, input logic [7:0] d);
    int n;
    @(posedge link_clk_i);
    #1;
    ptr_o = p;
    wdata_o = d;
    gc_addr_o = (k == 2);
    if (k == 2) begin
      @(posedge link_clk_i);
      #1;
      gc_addr_o = 1'b0;
    end
    {wr_stb_o, rd_stb_o, gc_byte_stb_o} = {k == 0, k == 1, k == 2};
    @(posedge link_clk_i);
    #1;
    {wr_stb_o, rd_stb_o, gc_byte_stb_o} = 3'b000;
    // Released bus carries no stale byte
    ptr_o = ~p;
    wdata_o = ~d;
    n = 0;
    while (busy_i !== 1'b0 && n < 40) begin
      @(posedge link_clk_i);
      n++;
    end
    // A link that never frees counts against the run
    if (n >= 40) n_stall_o++;
    repeat (3) @(posedge link_clk_i);
  endtask : req
endmodule : tmar_host_model

/* dv/tb_temp_monitor_alert_status_regs.sv */
// Self-checking bench of the alert/status register block
module tb_temp_monitor_alert_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_i, link_clk_i, reset_i, wr_stb_i, rd_stb_i, gc_addr_i, gc_byte_stb_i, gc_ack_o, busy_o;
  logic       rd_valid_o, conv_done_i, high_exceed_i, low_exceed_i, ot_exceed_i, open_diode_i, abort_conv_o;
  logic       fault_pin_i, fault_pin_o, fault_pin_oe_o, ot_pin_i, ot_pin_o, ot_pin_oe_o, abort_seen;
  logic [7:0] ptr_i, wdata_i, rdata_o, hysteresis_o, d;
  logic [1:0] conv_chan_i;
  logic [7:0] exp_q[$];
  int         n_errors, checked, seed, n_stall;
  tmar_regs u_tmar_regs (.mclk_i, .reset_i, .link_clk_i, .wr_stb_i, .rd_stb_i, .gc_addr_i, .gc_byte_stb_i,
    .ptr_i, .wdata_i, .gc_ack_o, .busy_o, .rd_valid_o, .rdata_o, .conv_done_i, .conv_chan_i, .high_exceed_i,
    .low_exceed_i, .ot_exceed_i, .open_diode_i, .abort_conv_o, .hysteresis_o, .fault_pin_i, .fault_pin_o,
    .fault_pin_oe_o, .ot_pin_i, .ot_pin_o, .ot_pin_oe_o);
  tmar_host_model u_tmar_host_model (.link_clk_i(link_clk_i), .busy_i(busy_o), .wr_stb_o(wr_stb_i),
    .rd_stb_o(rd_stb_i), .gc_addr_o(gc_addr_i), .gc_byte_stb_o(gc_byte_stb_i), .ptr_o(ptr_i), .wdata_o(wdata_i),
    .n_stall_o(n_stall));
  // Pulled-up open-drain pins
  assign fault_pin_i = fault_pin_oe_o ? fault_pin_o : 1'b1;
  assign ot_pin_i    = ot_pin_oe_o ? ot_pin_o : 1'b1;
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7.3;
    forever #15 link_clk_i = ~link_clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    u_tmar_host_model.req(1, p, 8'h00);
  endtask : rd
  task automatic wr(input int k, input logic [7:0] p, input logic [7:0] v);
    u_tmar_host_model.req(k, p, v);
  endtask : wr
  // Flags in order high, low, overtemp, open
  task automatic conv(input logic [1:0] ch, input logic [3:0] f);
    @(posedge mclk_i);
    #1;
    {conv_done_i, conv_chan_i, high_exceed_i, low_exceed_i, ot_exceed_i, open_diode_i} = {1'b1, ch, f};
    @(posedge mclk_i);
    #1;
    {conv_done_i, high_exceed_i, low_exceed_i, ot_exceed_i, open_diode_i} = {1'b0, ~f};
    repeat (4) @(posedge mclk_i);
  endtask : conv
  task automatic conclude;
    n_errors += n_stall + exp_q.size();
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge link_clk_i) begin
    if (rd_valid_o === 1'b1) chk(rdata_o, exp_q.pop_front());
    if (gc_addr_i) chk(8'(gc_ack_o), 8'h01);
  end
  always @(posedge mclk_i) if (abort_conv_o === 1'b1) abort_seen <= 1'b1;
  initial begin
    #300us;
    n_errors++;
    conclude();
  end
  initial begin
    {n_errors, checked, abort_seen, seed} = {32'h0, 32'h0, 1'b0, 32'hf3b0aa2a};
    {reset_i, conv_done_i, conv_chan_i, high_exceed_i, low_exceed_i, ot_exceed_i, open_diode_i} = 8'h80;
    repeat (10) @(posedge link_clk_i);
    @(posedge mclk_i);
    #1;
    reset_i = 1'b0;
    repeat (4) @(posedge link_clk_i);
    rd(8'h21, 8'h0a);
    rd(8'h22, 8'h70);
    wr(0, 8'hfe, 8'h00);
    wr(0, 8'hfd, 8'h00);
    rd(8'hfe, 8'h5a);
    rd(8'hfd, 8'ha2);
    rd(8'h40, 8'h00);
    d = 8'($random(seed)) & 8'h7f;
    wr(0, 8'h21, d);
    rd(8'h21, d);
    chk(hysteresis_o, d);
    d = 8'($random(seed));
    wr(0, 8'h22, d);
    rd(8'h22, d & 8'h7e);
    wr(0, 8'hfc, d);
    chk(8'(abort_seen), 8'h01);
    rd(8'h22, 8'h70);
    repeat (3) conv(2'h2, 4'b0010);
    chk(8'(ot_pin_oe_o), 8'h00);
    conv(2'h2, 4'b0010);
    chk(8'(ot_pin_oe_o), 8'h01);
    rd(8'h37, 8'h04);
    wr(2, 8'h00, 8'h05);
    chk(8'(ot_pin_oe_o), 8'h01);
    wr(2, 8'h00, 8'h06);
    chk(8'(ot_pin_oe_o), 8'h00);
    wr(0, 8'h22, 8'h02);
    conv(2'h1, 4'b1000);
    conv(2'h1, 4'b0000);
    conv(2'h1, 4'b1000);
    chk(8'(fault_pin_oe_o), 8'h00);
    rd(8'h02, 8'h10);
    conv(2'h1, 4'b1000);
    chk(8'(fault_pin_oe_o), 8'h01);
    rd(8'h35, 8'h02);
    conv(2'h1, 4'b0000);
    rd(8'h35, 8'h02);
    rd(8'h35, 8'h00);
    conv(2'h2, 4'b0101);
    rd(8'h36, 8'h04);
    rd(8'h1b, 8'h04);
    conv(2'h2, 4'b0101);
    chk(8'(fault_pin_oe_o), 8'h01);
    wr(0, 8'hfc, 8'h00);
    chk(8'(fault_pin_oe_o), 8'h00);
    wr(0, 8'h1f, 8'h02);
    conv(2'h1, 4'b1000);
    chk(8'(fault_pin_oe_o), 8'h00);
    conv(2'h0, 4'b1000);
    chk(8'(fault_pin_oe_o), 8'h01);
    conv(2'h0, 4'b0010);
    rd(8'h37, 8'h01);
    wr(0, 8'h22, 8'h06);
    conv(2'h0, 4'b0000);
    rd(8'h37, 8'h00);
    repeat (2) conv(2'h0, 4'b1000);
    chk(8'(fault_pin_oe_o), 8'h00);
    conv(2'h0, 4'b1000);
    chk(8'(fault_pin_oe_o), 8'h01);
    conclude();
  end
endmodule : tb_temp_monitor_alert_status_regs
